// ===== hdl/ch1_clear_pkg.sv
// constants, types and helpers shared by the channel 1 clear and rearm control block
package ch1_clear_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int HIST_W = 32;

  // register indices; byte address is four times the index
  localparam logic [13:0] CTRL_INDEX = 14'h2207;
  localparam logic [13:0] STATUS_INDEX = 14'h2220;
  localparam logic [13:0] HISTORY_INDEX = 14'h2221;
  localparam logic [15:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [15:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
  localparam logic [15:0] HISTORY_ADDR = {HISTORY_INDEX, 2'b00};

  // control register bit positions
  localparam int CTRL_REARM_BIT = 0;
  localparam int CTRL_HIST_CLR_BIT = 1;
  localparam int CTRL_RSVD_BIT = 2;
  localparam int CTRL_FAST_CLR_BIT = 3;
  localparam int CTRL_MUTE_CLR_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register bit positions
  localparam int STAT_MUTED_BIT = 0;
  localparam int STAT_HELD_BIT = 1;
  localparam int STAT_FAST_BIT = 2;
  localparam int STAT_HIST_BIT = 3;
  localparam int STAT_ARMED_BIT = 4;

  // mode field encodings, shared by the autounmute and autosync fields
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ANALOG_LOCK = 2'h1;
  localparam logic [1:0] MODE_FREQ_LOCK = 2'h2;
  localparam logic [1:0] MODE_PHASE_LOCK = 2'h3;

  typedef enum logic [1:0] {
    MUTE_WAIT = 2'b00,
    MUTE_OPEN = 2'b01,
    MUTE_HELD = 2'b11
  } mute_e;

  // turns a mode field into its qualifying condition
  function automatic logic mode_condition(input logic [1:0] mode, input logic analog_locked,
                                          input logic freq_locked, input logic phase_locked);
    logic met;
    met = 1'b0;
    case (mode)
      MODE_ANALOG_LOCK: met = analog_locked;
      MODE_FREQ_LOCK: met = freq_locked;
      MODE_PHASE_LOCK: met = phase_locked;
      default: met = 1'b0;
    endcase
    return met;
  endfunction

endpackage

// ===== hdl/ch1_sync_if.sv
// signals between the register side and the output autosync engine
`timescale 1ns/10ps
`default_nettype none
interface ch1_sync_if;
  logic rearm;
  logic immediate_ok;
  logic condition;
  logic sync_pulse;
  logic armed;
  modport ctrl (output rearm, output immediate_ok, output condition, input sync_pulse, input armed);
  modport engine (input rearm, input immediate_ok, input condition, output sync_pulse, output armed);
endinterface
`default_nettype wire

// ===== hdl/ch1_autosync.sv
// one-shot output autosync engine for channel 1
`timescale 1ns/10ps
`default_nettype none
module ch1_autosync
  import ch1_clear_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  ch1_sync_if.engine sync
);

  // armed out of reset so that the first qualifying condition syncs the outputs
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync.armed <= 1'b1;
      sync.sync_pulse <= 1'b0;
    end else if (enable) begin
      sync.sync_pulse <= 1'b0;
      if (sync.rearm && sync.immediate_ok) begin
        sync.sync_pulse <= 1'b1;
        sync.armed <= 1'b0;
      end else if (sync.rearm) begin
        sync.armed <= 1'b1;
      end else if (sync.armed && sync.condition) begin
        sync.sync_pulse <= 1'b1;
        sync.armed <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_one_shot;
    enable && !sync.armed && !sync.rearm |=> !sync.sync_pulse;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("sync fired while disarmed");

  property p_fire_disarms;
    enable && sync.armed && sync.condition && !sync.rearm |=> sync.sync_pulse ##1 !sync.sync_pulse || !enable;
  endproperty
  a_fire_disarms: assert property (p_fire_disarms) else $error("armed condition gave no single sync");

  property p_immediate;
    enable && sync.rearm && sync.immediate_ok |=> sync.sync_pulse && !sync.armed;
  endproperty
  a_immediate: assert property (p_immediate) else $error("rearm with lock gave no immediate sync");

  c_immediate: cover property (enable && sync.rearm && sync.immediate_ok ##1 sync.sync_pulse);

endmodule
`default_nettype wire

// ===== hdl/ch1_clear_ctrl.sv
// channel 1 clear and rearm control register with its mute, flag and history logic
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - writing one to control bit 4 lifts the automatic mute held on the channel 1 outputs.
// - after that clear the outputs stay muted until the autounmute mode condition is met again.
// - control bit 3 self-clears and writing one to it clears the fast-acquisition-done flag.
// - writing one to control bit 1 clears the history-available flag and pulses history_clear so the loop drops its accumulations.
// - the readable history word keeps its value until a new average arrives, which sets the flag again.
// - control bit 0 self-clears and writing one to it rearms the output autosync engine.
// - without a rearm the outputs are synced only once, when the autosync condition is first met.
// - after a rearm the outputs resync on the next qualifying autosync event.
// - with autosync mode 01 a rearm syncs at once, provided the analog loop is locked.
module ch1_clear_ctrl
  import ch1_clear_pkg::*;
#(
  parameter int HISTORY_W = HIST_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic automute_request,
  input wire logic [1:0] autounmute_mode,
  input wire logic [1:0] autosync_mode,
  input wire logic channel_one_analog_loop_locked,
  input wire logic channel_one_digital_loop_freq_locked,
  input wire logic channel_one_digital_loop_phase_locked,
  input wire logic fast_acq_done_set,
  input wire logic new_average_valid,
  input wire logic [HISTORY_W-1:0] new_average,
  output logic outputs_muted,
  output logic fast_acq_done,
  output logic history_available,
  output logic history_clear,
  output logic output_sync,
  output logic [HISTORY_W-1:0] history_word
);

  ch1_sync_if sync_link ();

  logic reserved_bit;
  logic accept;
  logic ctrl_write;
  mute_e mute_state;
  mute_e next_mute_state;
  logic unmute_met;

  // a request is served on the edge after waitrequest dropped
  assign accept = enable && (read || write) && !waitrequest;
  assign ctrl_write = accept && write && (address == CTRL_ADDR) && byteenable[0];
  assign unmute_met = mode_condition(autounmute_mode, channel_one_analog_loop_locked,
                                     channel_one_digital_loop_freq_locked,
                                     channel_one_digital_loop_phase_locked);

  // bus handshake: one wait cycle, then a single ready cycle per request
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if (enable) begin
      if (!waitrequest) begin
        waitrequest <= 1'b1;
      end else if (read || write) begin
        waitrequest <= 1'b0;
        readdata <= 32'h00000000;
        if (read && address == CTRL_ADDR) begin
          // action bits and reserved bits 7:5 read zero
          readdata[CTRL_RSVD_BIT] <= reserved_bit;
        end else if (read && address == STATUS_ADDR) begin
          readdata[STAT_MUTED_BIT] <= outputs_muted;
          readdata[STAT_HELD_BIT] <= (mute_state == MUTE_HELD);
          readdata[STAT_FAST_BIT] <= fast_acq_done;
          readdata[STAT_HIST_BIT] <= history_available;
          readdata[STAT_ARMED_BIT] <= sync_link.armed;
        end else if (read && address == HISTORY_ADDR) begin
          readdata[HISTORY_W-1:0] <= history_word;
        end
      end
    end
  end

  // reserved bit 2 is plain storage; bits 7:5 are dropped on write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reserved_bit <= CTRL_RESET[CTRL_RSVD_BIT];
    end else if (enable && ctrl_write) begin
      reserved_bit <= writedata[CTRL_RSVD_BIT];
    end
  end

  // mute handling; a fresh automute request outranks a manual clear in the same cycle
  always_comb begin
    next_mute_state = mute_state;
    case (mute_state)
      MUTE_WAIT: begin
        if (automute_request) begin
          next_mute_state = MUTE_HELD;
        end else if (unmute_met) begin
          next_mute_state = MUTE_OPEN;
        end
      end
      MUTE_OPEN: begin
        if (automute_request) begin
          next_mute_state = MUTE_HELD;
        end
      end
      default: next_mute_state = MUTE_HELD;
    endcase
    if (ctrl_write && writedata[CTRL_MUTE_CLR_BIT] && !automute_request) begin
      next_mute_state = MUTE_WAIT;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mute_state <= MUTE_WAIT;
      outputs_muted <= 1'b1;
    end else if (enable) begin
      mute_state <= next_mute_state;
      outputs_muted <= (next_mute_state != MUTE_OPEN);
    end
  end

  // fast acquisition done; the loop's set wins over a simultaneous clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fast_acq_done <= 1'b0;
    end else if (enable) begin
      if (fast_acq_done_set) begin
        fast_acq_done <= 1'b1;
      end else if (ctrl_write && writedata[CTRL_FAST_CLR_BIT]) begin
        fast_acq_done <= 1'b0;
      end
    end
  end

  // history: the pulse tells the loop to drop its accumulations, the shown word waits for a new average
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      history_available <= 1'b0;
      history_clear <= 1'b0;
    end else if (enable) begin
      history_clear <= ctrl_write && writedata[CTRL_HIST_CLR_BIT];
      if (new_average_valid) begin
        history_available <= 1'b1;
      end else if (ctrl_write && writedata[CTRL_HIST_CLR_BIT]) begin
        history_available <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      history_word <= '0;
    end else if (enable && new_average_valid) begin
      history_word <= new_average;
    end
  end

  // rearm is a one-cycle pulse; lock is sampled with it so the immediate sync uses the lock at the write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_link.rearm <= 1'b0;
      sync_link.immediate_ok <= 1'b0;
    end else if (enable) begin
      sync_link.rearm <= ctrl_write && writedata[CTRL_REARM_BIT];
      sync_link.immediate_ok <= (autosync_mode == MODE_ANALOG_LOCK) && channel_one_analog_loop_locked;
    end
  end

  assign sync_link.condition = mode_condition(autosync_mode, channel_one_analog_loop_locked,
                                              channel_one_digital_loop_freq_locked,
                                              channel_one_digital_loop_phase_locked);

  ch1_autosync u_autosync (
    .clock(clock),
    .reset_n(reset_n),
    .enable(enable),
    .sync(sync_link.engine)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      output_sync <= 1'b0;
    end else if (enable) begin
      output_sync <= sync_link.sync_pulse;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_bus_answer;
    enable && (read || write) && waitrequest ##1 enable |-> !waitrequest ##1 (waitrequest || !enable);
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered in one cycle");

  property p_mute_clear;
    ctrl_write && writedata[CTRL_MUTE_CLR_BIT] && !automute_request |=> mute_state == MUTE_WAIT && outputs_muted;
  endproperty
  a_mute_clear: assert property (p_mute_clear) else $error("mute clear did not restart mute handling");

  property p_stay_muted;
    enable && mute_state == MUTE_WAIT && !unmute_met |=> outputs_muted;
  endproperty
  a_stay_muted: assert property (p_stay_muted) else $error("outputs unmuted before condition met");

  property p_fast_clear;
    ctrl_write && writedata[CTRL_FAST_CLR_BIT] && !fast_acq_done_set |=> !fast_acq_done;
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast acquisition flag not cleared");

  property p_hist_clear;
    ctrl_write && writedata[CTRL_HIST_CLR_BIT] && !new_average_valid |=> !history_available && history_clear;
  endproperty
  a_hist_clear: assert property (p_hist_clear) else $error("history clear had no effect");

  property p_hist_hold;
    enable && !new_average_valid |=> $stable(history_word);
  endproperty
  a_hist_hold: assert property (p_hist_hold) else $error("history word changed without a new average");

  property p_hist_set;
    enable && new_average_valid |=> history_available && history_word == $past(new_average);
  endproperty
  a_hist_set: assert property (p_hist_set) else $error("new average not taken");

  property p_rearm;
    ctrl_write && writedata[CTRL_REARM_BIT] |=> sync_link.rearm;
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm write gave no rearm");

  property p_self_clear_read;
    enable && read && waitrequest && address == CTRL_ADDR |=> readdata[7:3] == 5'h00 && readdata[1:0] == 2'h0;
  endproperty
  a_self_clear_read: assert property (p_self_clear_read) else $error("action bits read nonzero");

  c_mute_cycle: cover property (ctrl_write && writedata[CTRL_MUTE_CLR_BIT] ##[1:20] !outputs_muted);
  c_history: cover property (history_clear ##[1:20] history_available);
  c_resync: cover property (sync_link.rearm ##[1:20] output_sync);

endmodule
`default_nettype wire

// ===== verification/tb_channel1_clear_rearm_control.sv
// self-checking bench for the channel 1 clear and rearm control register
`timescale 1ns/10ps
`default_nettype none
module tb_channel1_clear_rearm_control;
  import ch1_clear_pkg::*;
  logic clock, reset_n, enable, read, write, automute_request, fast_acq_done_set, new_average_valid;
  logic analog_lock, freq_lock, phase_lock, waitrequest, outputs_muted, fast_acq_done;
  logic history_available, history_clear, output_sync;
  logic [15:0] address;
  logic [31:0] writedata, readdata, new_average, history_word, v1, v2;
  logic [3:0] byteenable;
  logic [1:0] unmute_mode, sync_mode;
  logic [31:0] expq[$];
  int fails = 0;
  int comparisons = 0;
  int syncs = 0;
  int clears = 0;

  ch1_clear_ctrl uut (.clock(clock), .reset_n(reset_n), .enable(enable), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .automute_request(automute_request), .autounmute_mode(unmute_mode),
    .autosync_mode(sync_mode), .channel_one_analog_loop_locked(analog_lock),
    .channel_one_digital_loop_freq_locked(freq_lock), .channel_one_digital_loop_phase_locked(phase_lock),
    .fast_acq_done_set(fast_acq_done_set), .new_average_valid(new_average_valid), .new_average(new_average),
    .outputs_muted(outputs_muted), .fast_acq_done(fast_acq_done), .history_available(history_available),
    .history_clear(history_clear), .output_sync(output_sync), .history_word(history_word));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one Avalon transfer; the request is held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= rd;
    write <= ~rd;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check("waitrequest", waitrequest, 32'h0);
    check("wait states", n, 2);
    read <= 1'b0;
    write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // reads are judged here, against the oldest expectation noted by the driver
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expq.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("readdata", readdata, expq.pop_front());
    end
    if (output_sync === 1'b1) syncs++;
    if (history_clear === 1'b1) clears++;
  end

  initial begin
    repeat (6000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    {reset_n, read, write, automute_request, fast_acq_done_set, new_average_valid} = '0;
    {analog_lock, freq_lock, phase_lock, unmute_mode, sync_mode} = '0;
    enable = 1'b1;
    address = 16'h0000;
    writedata = 32'h0;
    byteenable = 4'hf;
    new_average = 32'h0;
    v1 = $urandom(37585);
    v1 = $urandom();
    v2 = $urandom();
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    wait_cycles(1);
    check("muted at reset", outputs_muted, 1'b1);
    rd(CTRL_ADDR, 32'h00);
    rd(STATUS_ADDR, 32'h11);
    rd(16'h0100, 32'h0);
    $display("test reset done");
    // lift mute, then force a hold-mute and clear it by software
    @(posedge clock);
    unmute_mode <= MODE_ANALOG_LOCK;
    analog_lock <= 1'b1;
    wait_cycles(3);
    check("muted open", outputs_muted, 1'b0);
    @(posedge clock);
    automute_request <= 1'b1;
    @(posedge clock);
    automute_request <= 1'b0;
    analog_lock <= 1'b0;
    wait_cycles(3);
    rd(STATUS_ADDR, 32'h13);
    bus(1'b0, CTRL_ADDR, 32'h10, 4'hf);
    wait_cycles(3);
    check("muted wait", outputs_muted, 1'b1);
    rd(STATUS_ADDR, 32'h11);
    rd(CTRL_ADDR, 32'h00);
    @(posedge clock);
    analog_lock <= 1'b1;
    wait_cycles(3);
    check("muted reopen", outputs_muted, 1'b0);
    $display("test mute done");
    // fast acquisition flag, refused lane, reserved storage bit
    @(posedge clock);
    fast_acq_done_set <= 1'b1;
    @(posedge clock);
    fast_acq_done_set <= 1'b0;
    bus(1'b0, CTRL_ADDR, 32'h08, 4'h0);
    check("fast kept", fast_acq_done, 1'b1);
    rd(STATUS_ADDR, 32'h14);
    bus(1'b0, CTRL_ADDR, 32'h08, 4'hf);
    check("fast cleared", fast_acq_done, 1'b0);
    // a set pulse while the clock enable is low must be lost
    @(posedge clock);
    enable <= 1'b0;
    fast_acq_done_set <= 1'b1;
    @(posedge clock);
    enable <= 1'b1;
    fast_acq_done_set <= 1'b0;
    wait_cycles(1);
    check("frozen flag", fast_acq_done, 1'b0);
    rd(CTRL_ADDR, 32'h00);
    bus(1'b0, CTRL_ADDR, 32'h04, 4'hf);
    rd(CTRL_ADDR, 32'h04);
    bus(1'b0, CTRL_ADDR, 32'h00, 4'hf);
    $display("test fast done");
    // history clear keeps the readable word until a new average lands
    @(posedge clock);
    new_average <= v1;
    new_average_valid <= 1'b1;
    @(posedge clock);
    new_average_valid <= 1'b0;
    wait_cycles(1);
    check("hist flag", history_available, 1'b1);
    bus(1'b0, CTRL_ADDR, 32'h02, 4'hf);
    check("hist flag clr", history_available, 1'b0);
    wait_cycles(2);
    check("hist word kept", history_word, v1);
    check("erase pulses", clears, 1);
    rd(HISTORY_ADDR, v1);
    @(posedge clock);
    new_average <= v2;
    new_average_valid <= 1'b1;
    @(posedge clock);
    new_average_valid <= 1'b0;
    wait_cycles(1);
    check("hist flag set", history_available, 1'b1);
    rd(STATUS_ADDR, 32'h18);
    check("hist word new", history_word, v2);
    $display("test history done");
    // autosync: once only, immediate on rearm in mode 01, then per mode
    @(posedge clock);
    sync_mode <= MODE_ANALOG_LOCK;
    wait_cycles(12);
    check("first sync", syncs, 1);
    rd(STATUS_ADDR, 32'h08);
    bus(1'b0, CTRL_ADDR, 32'h01, 4'hf);
    wait_cycles(8);
    check("immediate sync", syncs, 2);
    @(posedge clock);
    analog_lock <= 1'b0;
    bus(1'b0, CTRL_ADDR, 32'h01, 4'hf);
    wait_cycles(8);
    check("no sync unlocked", syncs, 2);
    @(posedge clock);
    analog_lock <= 1'b1;
    wait_cycles(8);
    check("rearmed sync", syncs, 3);
    for (int m = 2; m < 4; m++) begin
      @(posedge clock);
      sync_mode <= m[1:0];
      bus(1'b0, CTRL_ADDR, 32'h01, 4'hf);
      wait_cycles(8);
      check("no sync yet", syncs, m + 1);
      @(posedge clock);
      if (m == 2) freq_lock <= 1'b1;
      else phase_lock <= 1'b1;
      wait_cycles(8);
      check("mode sync", syncs, m + 2);
      wait_cycles(8);
      check("single sync", syncs, m + 2);
    end
    rd(CTRL_ADDR, 32'h00);
    $display("test autosync done");
    results();
  end
endmodule
`default_nettype wire
